// ==== verilog/trl_regs.sv ====
// temperature reading, limit registers and duty regulation loop
`timescale 1ns/1ps
module trl_regs #(
  parameter int unsigned BASE_CYCLES      = trl_pkg::DEF_BASE_CYCLES,
  parameter int unsigned FAST_SPEED_CYCLES = trl_pkg::DEF_BASE_CYCLES,
  parameter int unsigned SLOW_SPEED_CYCLES = trl_pkg::DEF_BASE_CYCLES * 4
) (
  input  wire logic                      clock_in,
  input  wire logic                      rstn_in,
  input  wire trl_pkg::trl_reg_req_t     reg_req_in,
  output logic [7:0]                     reg_rdata_out,
  input  wire logic                      sample_valid_in,
  input  wire trl_pkg::trl_readings_t    sample_in,
  input  wire trl_pkg::trl_mode_t        mode_in,
  input  wire trl_pkg::trl_loop_cfg_t    loop_cfg_in,
  input  wire logic [7:0]                sw_duty_in,
  input  wire logic [7:0]                desired_duty_in,
  input  wire logic [7:0]                active_temp_in,
  input  wire logic [15:0]               measured_rev_period_in,
  input  wire logic [15:0]               target_rev_period_in,
  output logic [7:0]                     duty_value_out,
  output trl_pkg::trl_limit_flags_t      limit_flags_out,
  output logic                           frozen_out
);
  import trl_pkg::*;

  // slowest auto pace shifts the base count left, so it must not overflow
  if (BASE_CYCLES < 1 || FAST_SPEED_CYCLES < 1 || SLOW_SPEED_CYCLES < 1 ||
      ((BASE_CYCLES << RATE_FASTEST) >> RATE_FASTEST) != BASE_CYCLES)
  begin : g_bad_param
    $error("trl_regs: cycle counts out of range");
  end

  // register state
  trl_readings_t    shadow_ff,  nxt_shadow;
  trl_readings_t    visible_ff, nxt_visible;
  logic             frozen_ff,  nxt_frozen;
  logic [7:0]       rdata_ff,   nxt_rdata;
  logic [7:0]       loc_upper_ff, loc_lower_ff, loc_therm_ff, loc_crit_ff;
  logic [7:0]       rem_upper_ff, rem_lower_ff, rem_therm_ff, rem_crit_ff;
  logic [7:0]       passive_ff;
  logic [7:0]       nxt_loc_upper, nxt_loc_lower, nxt_loc_therm, nxt_loc_crit;
  logic [7:0]       nxt_rem_upper, nxt_rem_lower, nxt_rem_therm, nxt_rem_crit;
  logic [7:0]       nxt_passive;
  trl_limit_flags_t flags_ff,   nxt_flags;
  logic             is_wr, is_rd;
  logic [7:0]       loc_hi, rem_hi, low_bits;

  assign is_wr = reg_req_in.wr;
  assign is_rd = reg_req_in.rd;
  assign loc_hi = visible_ff.local_reading[READ_W-1:FRAC_W];
  assign rem_hi = visible_ff.remote_reading[READ_W-1:FRAC_W];
  assign low_bits = {visible_ff.local_reading[FRAC_W-1:0], 2'b00,
                     visible_ff.remote_reading[FRAC_W-1:0]};

  always_comb
  begin
    nxt_shadow    = shadow_ff;
    nxt_visible   = visible_ff;
    nxt_frozen    = frozen_ff;
    nxt_rdata     = rdata_ff;
    nxt_loc_upper = loc_upper_ff;
    nxt_loc_lower = loc_lower_ff;
    nxt_loc_therm = loc_therm_ff;
    nxt_loc_crit  = loc_crit_ff;
    nxt_rem_upper = rem_upper_ff;
    nxt_rem_lower = rem_lower_ff;
    nxt_rem_therm = rem_therm_ff;
    nxt_rem_crit  = rem_crit_ff;
    nxt_passive   = passive_ff;
    // shadow keeps the newest conversion even while frozen
    if (sample_valid_in)
    begin
      nxt_shadow = sample_in;
    end
    if (!frozen_ff)
    begin
      nxt_visible = nxt_shadow;
    end
    if (is_rd)
    begin
      case (reg_req_in.addr)
        ADDR_LOW_BITS:    nxt_rdata = low_bits;
        ADDR_LOCAL_HIGH:  nxt_rdata = loc_hi;
        ADDR_REMOTE_HIGH: nxt_rdata = rem_hi;
        ADDR_LOC_UPPER:   nxt_rdata = loc_upper_ff;
        ADDR_LOC_LOWER:   nxt_rdata = loc_lower_ff;
        ADDR_LOC_THERM:   nxt_rdata = loc_therm_ff;
        ADDR_REM_UPPER:   nxt_rdata = rem_upper_ff;
        ADDR_REM_LOWER:   nxt_rdata = rem_lower_ff;
        ADDR_REM_THERM:   nxt_rdata = rem_therm_ff;
        ADDR_LOC_CRIT:    nxt_rdata = loc_crit_ff;
        ADDR_PASSIVE:     nxt_rdata = passive_ff;
        ADDR_REM_CRIT:    nxt_rdata = rem_crit_ff;
        default:          nxt_rdata = 8'h00;
      endcase
      if (reg_req_in.addr == ADDR_LOW_BITS)
      begin
        nxt_frozen  = 1'b1;
        nxt_visible = visible_ff;
      end
      else if (reg_req_in.addr == ADDR_REMOTE_HIGH)
      begin
        nxt_frozen = 1'b0;
      end
    end
    // limits change only by host writes, never by conversions
    if (is_wr)
    begin
      case (reg_req_in.addr)
        ADDR_LOC_UPPER: nxt_loc_upper = reg_req_in.wdata;
        ADDR_LOC_LOWER: nxt_loc_lower = reg_req_in.wdata;
        ADDR_LOC_THERM: nxt_loc_therm = reg_req_in.wdata;
        ADDR_REM_UPPER: nxt_rem_upper = reg_req_in.wdata;
        ADDR_REM_LOWER: nxt_rem_lower = reg_req_in.wdata;
        ADDR_REM_THERM: nxt_rem_therm = reg_req_in.wdata;
        ADDR_LOC_CRIT:  nxt_loc_crit  = reg_req_in.wdata;
        ADDR_REM_CRIT:  nxt_rem_crit  = reg_req_in.wdata;
        ADDR_PASSIVE:   nxt_passive   = reg_req_in.wdata & PASSIVE_MASK;
        default:        nxt_passive   = passive_ff;
      endcase
    end
  end

  // signed whole-degree comparisons
  always_comb
  begin
    nxt_flags.local_above_upper     = $signed(loc_hi) > $signed(loc_upper_ff);
    nxt_flags.local_below_lower     = $signed(loc_hi) < $signed(loc_lower_ff);
    nxt_flags.local_above_thermal   = $signed(loc_hi) > $signed(loc_therm_ff);
    nxt_flags.local_above_critical  = $signed(loc_hi) > $signed(loc_crit_ff);
    nxt_flags.remote_above_upper    = $signed(rem_hi) > $signed(rem_upper_ff);
    nxt_flags.remote_below_lower    = $signed(rem_hi) < $signed(rem_lower_ff);
    nxt_flags.remote_above_thermal  = $signed(rem_hi) > $signed(rem_therm_ff);
    nxt_flags.remote_above_critical = $signed(rem_hi) > $signed(rem_crit_ff);
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shadow_ff    <= {RST_HIGH_BYTE, 3'h0, RST_HIGH_BYTE, 3'h0};
      visible_ff   <= {RST_HIGH_BYTE, 3'h0, RST_HIGH_BYTE, 3'h0};
      frozen_ff    <= 1'b0;
      rdata_ff     <= RST_LOW_BITS;
      loc_upper_ff <= RST_LOC_UPPER;
      loc_lower_ff <= RST_LOC_LOWER;
      loc_therm_ff <= RST_LOC_THERM;
      loc_crit_ff  <= RST_LOC_CRIT;
      rem_upper_ff <= RST_REM_UPPER;
      rem_lower_ff <= RST_REM_LOWER;
      rem_therm_ff <= RST_REM_THERM;
      rem_crit_ff  <= RST_REM_CRIT;
      passive_ff   <= RST_PASSIVE;
      flags_ff     <= '0;
    end
    else
    begin
      shadow_ff    <= nxt_shadow;
      visible_ff   <= nxt_visible;
      frozen_ff    <= nxt_frozen;
      rdata_ff     <= nxt_rdata;
      loc_upper_ff <= nxt_loc_upper;
      loc_lower_ff <= nxt_loc_lower;
      loc_therm_ff <= nxt_loc_therm;
      loc_crit_ff  <= nxt_loc_crit;
      rem_upper_ff <= nxt_rem_upper;
      rem_lower_ff <= nxt_rem_lower;
      rem_therm_ff <= nxt_rem_therm;
      rem_crit_ff  <= nxt_rem_crit;
      passive_ff   <= nxt_passive;
      flags_ff     <= nxt_flags;
    end
  end

  assign reg_rdata_out   = rdata_ff;
  assign limit_flags_out = flags_ff;
  assign frozen_out      = frozen_ff;

  // duty regulation loop
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic [31:0] interval;
  logic        tick;
  logic [7:0]  duty_ff, nxt_duty;
  logic [7:0]  target, diff, step, deadband, move;
  logic        go_up, at_passive;
  logic [15:0] rev_diff;

  // interval selector only paces the auto loop, never the conversions
  always_comb
  begin
    if (mode_in == TRL_MODE_SPEED)
    begin
      interval = loop_cfg_in.fast_speed_monitor ? FAST_SPEED_CYCLES
                                                : SLOW_SPEED_CYCLES;
    end
    else
    begin
      interval = BASE_CYCLES << (RATE_FASTEST - loop_cfg_in.duty_recalc_interval_sel);
    end
    tick = (tick_cnt_ff >= interval - 32'd1);
    nxt_tick_cnt = tick ? 32'd0 : tick_cnt_ff + 32'd1;
  end

  assign at_passive = $signed(active_temp_in) <= $signed(passive_ff);
  assign rev_diff = (measured_rev_period_in > target_rev_period_in)
                  ? measured_rev_period_in - target_rev_period_in
                  : target_rev_period_in - measured_rev_period_in;

  always_comb
  begin
    nxt_duty = duty_ff;
    target   = at_passive ? DUTY_ZERO : desired_duty_in;
    go_up    = target > duty_ff;
    diff     = go_up ? target - duty_ff : duty_ff - target;
    step     = 8'h01 << loop_cfg_in.duty_increment_sel;
    deadband = {6'h00, loop_cfg_in.adjust_deadband_sel} + 8'h01;
    move     = (diff < step) ? diff : step;
    case (mode_in)
      TRL_MODE_OPEN:
      begin
        nxt_duty = sw_duty_in;
      end
      TRL_MODE_AUTO:
      begin
        if (tick && at_passive)
        begin
          nxt_duty = DUTY_ZERO;
        end
        else if (tick && diff > deadband)
        begin
          if (!loop_cfg_in.gradual_change_enable)
          begin
            nxt_duty = target;
          end
          else
          begin
            nxt_duty = go_up ? duty_ff + move : duty_ff - move;
          end
        end
      end
      TRL_MODE_SPEED:
      begin
        // a longer revolution period means the fan is too slow
        if (tick && rev_diff > SPEED_TOLERANCE)
        begin
          if (measured_rev_period_in > target_rev_period_in)
          begin
            nxt_duty = (DUTY_FULL - duty_ff < step) ? DUTY_FULL : duty_ff + step;
          end
          else
          begin
            nxt_duty = (duty_ff < step) ? DUTY_ZERO : duty_ff - step;
          end
        end
      end
      default:
      begin
        nxt_duty = duty_ff;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick_cnt_ff <= 32'd0;
      duty_ff     <= DUTY_ZERO;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      duty_ff     <= nxt_duty;
    end
  end

  assign duty_value_out = duty_ff;

  // checks
  sequence s_low_read;
    is_rd && reg_req_in.addr == ADDR_LOW_BITS;
  endsequence
  sequence s_remote_read;
    is_rd && reg_req_in.addr == ADDR_REMOTE_HIGH;
  endsequence

  a_freeze_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_low_read |=> frozen_ff)
    else $error("low byte read did not freeze readings");
  a_freeze_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
    frozen_ff && !(is_rd && reg_req_in.addr == ADDR_REMOTE_HIGH) |=> $stable(visible_ff))
    else $error("readings changed while frozen");
  a_freeze_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_remote_read |=> !frozen_ff)
    else $error("remote high read did not release freeze");
  a_low_byte_pack: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_low_read |=> rdata_ff == {$past(visible_ff.local_reading[FRAC_W-1:0]), 2'b00,
                                $past(visible_ff.remote_reading[FRAC_W-1:0])})
    else $error("low byte packing wrong");
  a_passive_mask: assert property (@(posedge clock_in) disable iff (!rstn_in)
    passive_ff[7:6] == 2'b00)
    else $error("passive limit top bits set");
  a_refresh_shadow: assert property (@(posedge clock_in) disable iff (!rstn_in)
    sample_valid_in |=> shadow_ff == $past(sample_in))
    else $error("sample not captured");
  a_open_follow: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_OPEN |=> duty_ff == $past(sw_duty_in))
    else $error("open loop duty not applied");
  a_deadband_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_AUTO && !at_passive && diff <= deadband |=> $stable(duty_ff))
    else $error("duty moved inside deadband");
  a_passive_zero: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_AUTO && tick && at_passive |=> duty_ff == DUTY_ZERO)
    else $error("duty not zero at passive limit");
  a_speed_tol: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_SPEED && rev_diff <= SPEED_TOLERANCE |=> $stable(duty_ff))
    else $error("speed loop moved within tolerance");
  a_step_bound: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_AUTO && loop_cfg_in.gradual_change_enable && !at_passive
    |=> (duty_ff - $past(duty_ff) <= $past(step)) || ($past(duty_ff) - duty_ff <= $past(step)))
    else $error("duty step too large");

  sequence s_local_read;
    is_rd && reg_req_in.addr == ADDR_LOCAL_HIGH;
  endsequence
  sequence s_release_idle;
    !frozen_ff && !sample_valid_in && !is_rd;
  endsequence

  a_local_high: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_local_read |=> rdata_ff == $past(loc_hi))
    else $error("local high byte read wrong");
  a_remote_high: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_remote_read |=> rdata_ff == $past(rem_hi))
    else $error("remote high byte read wrong");
  a_release_update: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_remote_read ##1 s_release_idle |=> visible_ff == $past(shadow_ff))
    else $error("readings not refreshed after release");
  a_auto_pace: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_AUTO && !tick |=> $stable(duty_ff))
    else $error("auto duty moved between updates");
  a_speed_pace: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_in == TRL_MODE_SPEED && !tick |=> $stable(duty_ff))
    else $error("speed duty moved between updates");
  a_limit_keep: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !is_wr |=> $stable({loc_upper_ff, loc_lower_ff, loc_therm_ff, loc_crit_ff,
                        rem_upper_ff, rem_lower_ff, rem_therm_ff, rem_crit_ff, passive_ff}))
    else $error("limit changed without a write");
  a_passive_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
    is_wr && reg_req_in.addr == ADDR_PASSIVE
    |=> passive_ff == ($past(reg_req_in.wdata) & PASSIVE_MASK))
    else $error("passive limit write not masked");
endmodule // trl_regs

// ==== pkg/trl_pkg.sv ====
// constants and types for the temperature reading and limit register bank
package trl_pkg;
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned MAX_UPDATES_PER_S = 8;
  localparam int unsigned DEF_BASE_CYCLES   = CLK_HZ / MAX_UPDATES_PER_S;
  localparam logic [2:0]  RATE_FASTEST      = 3'h7;
  localparam logic [15:0] SPEED_TOLERANCE   = 16'h000a;

  localparam logic [7:0] ADDR_LOW_BITS    = 8'h06;
  localparam logic [7:0] ADDR_LOCAL_HIGH  = 8'h0a;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_LOC_UPPER   = 8'h14;
  localparam logic [7:0] ADDR_LOC_LOWER   = 8'h15;
  localparam logic [7:0] ADDR_LOC_THERM   = 8'h16;
  localparam logic [7:0] ADDR_REM_UPPER   = 8'h18;
  localparam logic [7:0] ADDR_REM_LOWER   = 8'h19;
  localparam logic [7:0] ADDR_REM_THERM   = 8'h1a;
  localparam logic [7:0] ADDR_LOC_CRIT    = 8'h1b;
  localparam logic [7:0] ADDR_PASSIVE     = 8'h1c;
  localparam logic [7:0] ADDR_REM_CRIT    = 8'h1d;

  localparam logic [7:0] RST_HIGH_BYTE  = 8'h80;
  localparam logic [7:0] RST_LOW_BITS   = 8'h00;
  localparam logic [7:0] RST_LOC_UPPER  = 8'h3c;
  localparam logic [7:0] RST_LOC_LOWER  = 8'h00;
  localparam logic [7:0] RST_LOC_THERM  = 8'h46;
  localparam logic [7:0] RST_REM_UPPER  = 8'h50;
  localparam logic [7:0] RST_REM_LOWER  = 8'h00;
  localparam logic [7:0] RST_REM_THERM  = 8'h64;
  localparam logic [7:0] RST_LOC_CRIT   = 8'h50;
  localparam logic [7:0] RST_PASSIVE    = 8'h00;
  localparam logic [7:0] RST_REM_CRIT   = 8'h69;
  localparam logic [7:0] PASSIVE_MASK   = 8'h3f;
  localparam logic [7:0] DUTY_ZERO      = 8'h00;
  localparam logic [7:0] DUTY_FULL      = 8'hff;

  localparam int unsigned READ_W = 11;
  localparam int unsigned FRAC_W = 3;

  typedef enum logic [1:0] {
    TRL_MODE_OPEN,
    TRL_MODE_AUTO,
    TRL_MODE_SPEED,
    TRL_MODE_SPARE
  } trl_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } trl_reg_req_t;

  typedef struct packed {
    logic [READ_W-1:0] local_reading;
    logic [READ_W-1:0] remote_reading;
  } trl_readings_t;

  typedef struct packed {
    logic [2:0] duty_recalc_interval_sel;
    logic [1:0] adjust_deadband_sel;
    logic [1:0] duty_increment_sel;
    logic       gradual_change_enable;
    logic       fast_speed_monitor;
  } trl_loop_cfg_t;

  typedef struct packed {
    logic local_above_upper;
    logic local_below_lower;
    logic local_above_thermal;
    logic local_above_critical;
    logic remote_above_upper;
    logic remote_below_lower;
    logic remote_above_thermal;
    logic remote_above_critical;
  } trl_limit_flags_t;
endpackage

// ==== verification/trl_host_model.sv ====
// host software model issuing register accesses to the bank
`timescale 1ns/1ps
module trl_host_model (
  input  wire logic            clock_in,
  output trl_pkg::trl_reg_req_t reg_req_out
);
  import trl_pkg::*;

  initial reg_req_out = '{addr: 8'hff, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

  // one access per call, held over exactly one rising edge, never rd and wr together
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        input int gap);
    repeat (gap) @(negedge clock_in);
    @(negedge clock_in);
    reg_req_out = '{addr: a, wr: w, rd: ~w, wdata: d};
    @(negedge clock_in);
    // released address and data lines show the inverse and both strobes drop, never the stale request
    reg_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule // trl_host_model

// ==== verification/trl_regs_tb.sv ====
// self-checking bench for the temperature register bank
`timescale 1ns/1ps
module trl_regs_tb;
  import trl_pkg::*;
  logic             clock_in, rstn_in, sample_valid, frozen, rd_d;
  trl_reg_req_t     req;
  trl_readings_t    smp;
  trl_mode_t        mode;
  trl_loop_cfg_t    cfg;
  trl_limit_flags_t flags;
  logic [7:0]       rdata, sw_duty, desired, act_temp, duty, wv;
  logic [15:0]      meas, target;
  logic [10:0]      loc, rem, loc2, rem2;
  logic [7:0]       exp_q[$];
  logic [7:0]       shadow[12];
  int               error_cnt = 0;
  int               checked = 0;
  integer           seed = 32'h4f6b571f;
  logic [7:0] addr_t[12] = '{ADDR_LOW_BITS, ADDR_LOCAL_HIGH, ADDR_REMOTE_HIGH, ADDR_LOC_UPPER,
    ADDR_LOC_LOWER, ADDR_LOC_THERM, ADDR_REM_UPPER, ADDR_REM_LOWER, ADDR_REM_THERM,
    ADDR_LOC_CRIT, ADDR_PASSIVE, ADDR_REM_CRIT};
  logic [7:0] rst_t[12] = '{RST_LOW_BITS, RST_HIGH_BYTE, RST_HIGH_BYTE, RST_LOC_UPPER,
    RST_LOC_LOWER, RST_LOC_THERM, RST_REM_UPPER, RST_REM_LOWER, RST_REM_THERM,
    RST_LOC_CRIT, RST_PASSIVE, RST_REM_CRIT};

  trl_regs #(
    .BASE_CYCLES      (4),
    .FAST_SPEED_CYCLES(4),
    .SLOW_SPEED_CYCLES(16)
  ) dut (
    .clock_in              (clock_in),
    .rstn_in               (rstn_in),
    .reg_req_in            (req),
    .reg_rdata_out         (rdata),
    .sample_valid_in       (sample_valid),
    .sample_in             (smp),
    .mode_in               (mode),
    .loop_cfg_in           (cfg),
    .sw_duty_in            (sw_duty),
    .desired_duty_in       (desired),
    .active_temp_in        (act_temp),
    .measured_rev_period_in(meas),
    .target_rev_period_in  (target),
    .duty_value_out        (duty),
    .limit_flags_out       (flags),
    .frozen_out            (frozen)
  );

  trl_host_model host (
    .clock_in   (clock_in),
    .reg_req_out(req)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // note the expected answer, then let the host issue the read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(a, 1'b0, 8'h00, $unsigned($random(seed)) % 3);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(a, 1'b1, d, 0);
  endtask

  task automatic sample(input logic [10:0] l, input logic [10:0] r);
    @(negedge clock_in);
    smp = '{local_reading: l, remote_reading: r};
    sample_valid = 1'b1;
    @(negedge clock_in);
    sample_valid = 1'b0;
    smp = trl_readings_t'(~smp);
    repeat (2) @(negedge clock_in);
  endtask

  task automatic wait_duty(input logic [7:0] e, input int n);
    for (int i = 0; i < n && duty !== e; i++) @(negedge clock_in);
    cmp(duty, e);
  endtask

  task automatic hold_duty(input logic [7:0] e, input int n);
    repeat (n)
    begin
      @(negedge clock_in);
      cmp(duty, e);
    end
  endtask

  // read answers land on the rising edge that takes the request and are checked at the next falling edge
  always @(posedge clock_in) rd_d <= req.rd;
  always @(negedge clock_in)
    if (rd_d === 1'b1 && exp_q.size() != 0)
      cmp(rdata, exp_q.pop_front());

  initial
  begin
    #(50 * 6000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rstn_in = 1'b0;
    sample_valid = 1'b0;
    smp = '0;
    mode = TRL_MODE_AUTO;
    cfg = '0;
    sw_duty = 8'h00;
    desired = 8'h00;
    act_temp = 8'h00;
    meas = 16'h0000;
    target = 16'h0000;
    repeat (2) @(negedge clock_in);
    rstn_in = 1'b1;
    for (int k = 0; k < 12; k++) rd_chk(addr_t[k], rst_t[k]);
    rd_chk(8'h07, 8'h00);
    wr(ADDR_LOCAL_HIGH, 8'h55);
    rd_chk(ADDR_LOCAL_HIGH, RST_HIGH_BYTE);
    for (int k = 3; k < 12; k++)
    begin
      wv = $random(seed);
      wr(addr_t[k], wv);
      shadow[k] = (k == 10) ? (wv & PASSIVE_MASK) : wv;
    end
    for (int k = 3; k < 12; k++) rd_chk(addr_t[k], shadow[k]);
    // readings move on while the duty pace is slowest
    loc = $random(seed);
    rem = $random(seed);
    sample(loc, rem);
    rd_chk(ADDR_REMOTE_HIGH, rem[10:3]);
    rd_chk(ADDR_LOCAL_HIGH, loc[10:3]);
    loc2 = $random(seed);
    rem2 = $random(seed);
    sample(loc2, rem2);
    rd_chk(ADDR_LOCAL_HIGH, loc2[10:3]);
    rd_chk(ADDR_LOW_BITS, {loc2[2:0], 2'b00, rem2[2:0]});
    cmp({7'h00, frozen}, 8'h01);
    sample(loc, rem);
    rd_chk(ADDR_LOCAL_HIGH, loc2[10:3]);
    rd_chk(ADDR_REMOTE_HIGH, rem2[10:3]);
    cmp({7'h00, frozen}, 8'h00);
    repeat (2) @(negedge clock_in);
    rd_chk(ADDR_LOW_BITS, {loc[2:0], 2'b00, rem[2:0]});
    rd_chk(ADDR_REMOTE_HIGH, rem[10:3]);
    for (int k = 3; k < 12; k++) rd_chk(addr_t[k], shadow[k]);
    // known limits, then signed compares
    for (int k = 3; k < 12; k++)
    begin
      shadow[k] = (k == 4 || k == 7) ? 8'h00 : ((k == 3 || k == 6) ? 8'h10 : 8'h40);
      if (k != 10) wr(addr_t[k], shadow[k]);
    end
    sample({8'h20, 3'h5}, {8'h00, 3'h2});
    cmp(flags, 8'h80);
    sample({8'h7f, 3'h0}, {8'h80, 3'h0});
    cmp(flags, 8'hb4);
    loc = {8'hf0, 3'h0};
    rem = {8'h7f, 3'h7};
    sample(loc, rem);
    cmp(flags, 8'h4b);
    // automatic loop at the fastest pace
    wr(ADDR_PASSIVE, 8'h10);
    act_temp = 8'h20;
    desired = 8'h80;
    cfg = '{duty_recalc_interval_sel: 3'h7, adjust_deadband_sel: 2'h0, duty_increment_sel: 2'h3,
            gradual_change_enable: 1'b0, fast_speed_monitor: 1'b1};
    wait_duty(8'h80, 7);
    desired = 8'h81;
    hold_duty(8'h80, 12);
    cfg.gradual_change_enable = 1'b1;
    desired = 8'h83;
    wait_duty(8'h83, 7);
    desired = 8'ha3;
    wait_duty(8'h8b, 7);
    wait_duty(8'h93, 5);
    cfg.adjust_deadband_sel = 2'h3;
    desired = 8'h97;
    hold_duty(8'h93, 8);
    cfg.duty_increment_sel = 2'h0;
    desired = 8'h98;
    wait_duty(8'h94, 7);
    act_temp = 8'h10;
    wait_duty(8'h00, 7);
    mode = TRL_MODE_OPEN;
    for (int k = 0; k < 4; k++)
    begin
      sw_duty = $random(seed);
      repeat (2) @(negedge clock_in);
      cmp(duty, sw_duty);
    end
    sw_duty = 8'h40;
    repeat (2) @(negedge clock_in);
    // speed regulation ignores the interval selector
    mode = TRL_MODE_SPEED;
    cfg.duty_increment_sel = 2'h1;
    cfg.duty_recalc_interval_sel = 3'h0;
    target = 16'h1000;
    meas = 16'h100a;
    hold_duty(8'h40, 12);
    meas = 16'h100b;
    wait_duty(8'h42, 7);
    meas = 16'h0ff5;
    wait_duty(8'h40, 7);
    cfg.fast_speed_monitor = 1'b0;
    meas = 16'h100b;
    wait_duty(8'h42, 20);
    hold_duty(8'h42, 12);
    // spare mode keeps the duty where it is
    mode = TRL_MODE_SPARE;
    hold_duty(8'h42, 8);
    // abandoned sequence cleared by reset
    rd_chk(ADDR_LOW_BITS, {loc[2:0], 2'b00, rem[2:0]});
    cmp({7'h00, frozen}, 8'h01);
    rstn_in = 1'b0;
    @(negedge clock_in);
    rstn_in = 1'b1;
    cmp({7'h00, frozen}, 8'h00);
    rd_chk(ADDR_LOCAL_HIGH, RST_HIGH_BYTE);
    sample(loc, rem);
    rd_chk(ADDR_LOCAL_HIGH, loc[10:3]);
    repeat (2) @(negedge clock_in);
    finish_test();
  end
endmodule // trl_regs_tb
